// file: design/charger_cfg_pkg.sv
package charger_cfg_pkg;

    // Register offsets on the serial control bus
    localparam logic [7:0] BATTERY_VOLTAGE_CONFIG_OFFSET   = 8'h04;
    localparam logic [7:0] TERMINATION_TIMER_CONFIG_OFFSET = 8'h05;
    localparam logic [7:0] MISC_OPERATION_CONTROL_OFFSET   = 8'h06;

    // Reset values
    localparam logic [7:0] BATTERY_VOLTAGE_CONFIG_RESET   = 8'ha3;
    localparam logic [7:0] TERMINATION_TIMER_CONFIG_RESET = 8'h3a;
    localparam logic [7:0] MISC_OPERATION_CONTROL_RESET   = 8'hc0;

    // Bits restored by watchdog expiry
    localparam logic [7:0] BATTERY_WATCHDOG_MASK = 8'hff;
    localparam logic [7:0] TIMER_WATCHDOG_MASK   = 8'h1f;
    localparam logic [7:0] MISC_WATCHDOG_MASK    = 8'hdf;

    // Watchdog limit codes
    localparam logic [1:0] WATCHDOG_LIMIT_OFF = 2'h0;

    // Charge state codes seen on the status input
    localparam logic [1:0] CHARGE_STATE_IDLE = 2'h0;
    localparam logic [1:0] CHARGE_STATE_PRE  = 2'h1;
    localparam logic [1:0] CHARGE_STATE_FAST = 2'h2;
    localparam logic [1:0] CHARGE_STATE_DONE = 2'h3;

    typedef struct packed {
        logic [5:0] regulation_voltage_code;
        logic       precharge_threshold_high;
        logic       recharge_offset_large;
    } battery_voltage_config_type;

    typedef struct packed {
        logic       discharge_watchdog_enable;
        logic [1:0] watchdog_limit;
        logic       termination_enable;
        logic       safety_timer_enable;
        logic [1:0] fast_charge_timer_length;
        logic       post_termination_charge_keep;
    } termination_timer_config_type;

    typedef struct packed {
        logic temperature_monitor_enable;
        logic timer_doubling_enable;
        logic battery_switch_off;
        logic power_good_irq_mask;
        logic end_of_charge_irq_mask;
        logic charge_state_irq_mask;
        logic temperature_irq_mask;
        logic battery_overvoltage_irq_mask;
    } misc_operation_control_type;

    typedef struct packed {
        logic       write;
        logic       read;
        logic [7:0] address;
        logic [7:0] data;
    } reg_request_type;

    typedef struct packed {
        logic power_good;
        logic end_of_charge;
        logic temperature;
        logic battery_overvoltage;
    } event_type;

    typedef struct packed {
        battery_voltage_config_type   battery_voltage_config;
        termination_timer_config_type termination_timer_config;
        misc_operation_control_type   misc_operation_control;
        logic [1:0]                   charge_state_last;
        logic [7:0]                   read_data;
        logic                         irq;
    } state_type;

endpackage

// file: design/charger_config_registers.sv
`timescale 1ns/10ps
// Functional notes
// - Battery bits 7:2: regulation 3.60V plus 15mV per step, default 4.2V.
// - Battery bit 1 picks precharge threshold 2.8V or 3.0V, default 3.0V.
// - Battery bit 0 picks recharge drop 100mV or 200mV, default 200mV.
// - Battery register returns to 0xa3 on any reset or watchdog expiry.
// - Timer bits 6:5 give watchdog limit off, 40s, 80s, 160s; default 40s.
// - Limit 00 keeps watchdog inactive regardless of discharge enable bit 7.
// - Timer register 0x3a on reset; watchdog expiry restores bits 4:0 only.
// - Timer bit 4 permits charge termination, default permitted.
// - Bit 3 enables safety timer; bits 2:1 pick 3, 5, 8, 12 hours.
// - Timer bit 0 keeps charge current flowing after termination.
// - Misc bit 6 doubles safety timer during power-path management.
// - Misc bit 5 forces battery switch off; it never turns it on.
// - Misc bits 4:0 mask five interrupts; 1 suppresses.
// - Unmasked charge state interrupt fires on idle, precharge, fast moves.
// - Misc register 0xc0 on reset; watchdog restores all but switch off bit.
// - Writing 1 to register reset restores defaults; 0 changes nothing.
module charger_config_registers (
    input  wire logic                            clk_sys_i,
    input  wire logic                            nrst_i,
    input  wire charger_cfg_pkg::reg_request_type req_i,
    input  wire logic                            register_reset_i,
    input  wire logic                            watchdog_expiry_reset_i,
    input  wire logic                            discharge_mode_i,
    input  wire logic                            power_path_management_i,
    input  wire logic [1:0]                      charge_state_i,
    input  wire charger_cfg_pkg::event_type      events_i,
    output logic [7:0]                           read_data_o,
    output logic [5:0]                           regulation_voltage_code_o,
    output logic                                 precharge_threshold_high_o,
    output logic                                 recharge_offset_large_o,
    output logic                                 watchdog_active_o,
    output logic [1:0]                           watchdog_limit_o,
    output logic                                 termination_enable_o,
    output logic                                 safety_timer_enable_o,
    output logic [1:0]                           fast_charge_timer_length_o,
    output logic                                 post_termination_charge_keep_o,
    output logic                                 safety_timer_doubled_o,
    output logic                                 temperature_monitor_enable_o,
    output logic                                 battery_switch_off_o,
    output logic                                 irq_o
);

    charger_cfg_pkg::state_type state_reg;
    charger_cfg_pkg::state_type state_next;

    function automatic logic charging_state(input logic [1:0] s);
        charging_state = (s == charger_cfg_pkg::CHARGE_STATE_IDLE) ||
                         (s == charger_cfg_pkg::CHARGE_STATE_PRE)  ||
                         (s == charger_cfg_pkg::CHARGE_STATE_FAST);
    endfunction

    logic [7:0] battery_now;
    logic [7:0] timer_now;
    logic [7:0] misc_now;
    logic       state_change;

    always_comb begin
        state_next  = state_reg;
        battery_now = state_reg.battery_voltage_config;
        timer_now   = state_reg.termination_timer_config;
        misc_now    = state_reg.misc_operation_control;
        if (register_reset_i) begin
            battery_now = charger_cfg_pkg::BATTERY_VOLTAGE_CONFIG_RESET;
            timer_now   = charger_cfg_pkg::TERMINATION_TIMER_CONFIG_RESET;
            misc_now    = charger_cfg_pkg::MISC_OPERATION_CONTROL_RESET;
        end else if (watchdog_expiry_reset_i) begin
            battery_now = charger_cfg_pkg::BATTERY_VOLTAGE_CONFIG_RESET;
            timer_now   = (timer_now & ~charger_cfg_pkg::TIMER_WATCHDOG_MASK)
                | (charger_cfg_pkg::TERMINATION_TIMER_CONFIG_RESET
                   & charger_cfg_pkg::TIMER_WATCHDOG_MASK);
            misc_now    = (misc_now & ~charger_cfg_pkg::MISC_WATCHDOG_MASK)
                | (charger_cfg_pkg::MISC_OPERATION_CONTROL_RESET
                   & charger_cfg_pkg::MISC_WATCHDOG_MASK);
        end else if (req_i.write) begin
            case (req_i.address)
                charger_cfg_pkg::BATTERY_VOLTAGE_CONFIG_OFFSET: begin
                    battery_now = req_i.data;
                end
                charger_cfg_pkg::TERMINATION_TIMER_CONFIG_OFFSET: begin
                    timer_now = req_i.data;
                end
                charger_cfg_pkg::MISC_OPERATION_CONTROL_OFFSET: begin
                    misc_now = req_i.data;
                end
                default: begin
                end
            endcase
        end
        state_next.battery_voltage_config   = battery_now;
        state_next.termination_timer_config = timer_now;
        state_next.misc_operation_control   = misc_now;

        if (req_i.read) begin
            case (req_i.address)
                charger_cfg_pkg::BATTERY_VOLTAGE_CONFIG_OFFSET:
                    state_next.read_data = state_reg.battery_voltage_config;
                charger_cfg_pkg::TERMINATION_TIMER_CONFIG_OFFSET:
                    state_next.read_data = state_reg.termination_timer_config;
                charger_cfg_pkg::MISC_OPERATION_CONTROL_OFFSET:
                    state_next.read_data = state_reg.misc_operation_control;
                default:
                    state_next.read_data = 8'h00;
            endcase
        end

        // Status transitions among idle, precharge and fast charge only
        state_change = (charge_state_i != state_reg.charge_state_last) &&
                       charging_state(charge_state_i) &&
                       charging_state(state_reg.charge_state_last);
        state_next.charge_state_last = charge_state_i;
        state_next.irq =
            (events_i.power_good &&
             !state_reg.misc_operation_control.power_good_irq_mask) ||
            (events_i.end_of_charge &&
             !state_reg.misc_operation_control.end_of_charge_irq_mask) ||
            (state_change &&
             !state_reg.misc_operation_control.charge_state_irq_mask) ||
            (events_i.temperature &&
             !state_reg.misc_operation_control.temperature_irq_mask) ||
            (events_i.battery_overvoltage &&
             !state_reg.misc_operation_control.battery_overvoltage_irq_mask);
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_reg.battery_voltage_config <=
                charger_cfg_pkg::BATTERY_VOLTAGE_CONFIG_RESET;
            state_reg.termination_timer_config <=
                charger_cfg_pkg::TERMINATION_TIMER_CONFIG_RESET;
            state_reg.misc_operation_control <=
                charger_cfg_pkg::MISC_OPERATION_CONTROL_RESET;
            state_reg.charge_state_last <= charger_cfg_pkg::CHARGE_STATE_IDLE;
            state_reg.read_data         <= 8'h00;
            state_reg.irq               <= 1'b0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign read_data_o = state_reg.read_data;
    assign regulation_voltage_code_o =
        state_reg.battery_voltage_config.regulation_voltage_code;
    assign precharge_threshold_high_o =
        state_reg.battery_voltage_config.precharge_threshold_high;
    assign recharge_offset_large_o =
        state_reg.battery_voltage_config.recharge_offset_large;
    assign watchdog_limit_o =
        state_reg.termination_timer_config.watchdog_limit;
    assign watchdog_active_o =
        (state_reg.termination_timer_config.watchdog_limit !=
         charger_cfg_pkg::WATCHDOG_LIMIT_OFF) &&
        (!discharge_mode_i ||
         state_reg.termination_timer_config.discharge_watchdog_enable);
    assign termination_enable_o =
        state_reg.termination_timer_config.termination_enable;
    assign safety_timer_enable_o =
        state_reg.termination_timer_config.safety_timer_enable;
    assign fast_charge_timer_length_o =
        state_reg.termination_timer_config.fast_charge_timer_length;
    assign post_termination_charge_keep_o =
        state_reg.termination_timer_config.post_termination_charge_keep;
    assign safety_timer_doubled_o =
        state_reg.misc_operation_control.timer_doubling_enable &&
        power_path_management_i;
    assign temperature_monitor_enable_o =
        state_reg.misc_operation_control.temperature_monitor_enable;
    assign battery_switch_off_o =
        state_reg.misc_operation_control.battery_switch_off;
    assign irq_o = state_reg.irq;

endmodule

// file: verification/charger_cfg_monitor.sv
`timescale 1ns/10ps
module charger_cfg_monitor (
    input wire logic       clk_sys_i,
    input wire logic       nrst_i,
    input wire logic       register_reset_i,
    input wire logic       watchdog_expiry_reset_i,
    input wire logic       discharge_mode_i,
    input wire logic       power_path_management_i,
    input wire logic [5:0] regulation_voltage_code_o,
    input wire logic       precharge_threshold_high_o,
    input wire logic       watchdog_active_o,
    input wire logic [1:0] watchdog_limit_o,
    input wire logic       termination_enable_o,
    input wire logic       safety_timer_doubled_o,
    input wire logic       temperature_monitor_enable_o,
    input wire logic       battery_switch_off_o,
    input wire logic       irq_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!nrst_i);
    wire wd_only = watchdog_expiry_reset_i && !register_reset_i;
    AST_BATT_RESTORE: assert property (
        register_reset_i || watchdog_expiry_reset_i |=>
        regulation_voltage_code_o == 6'h28 && precharge_threshold_high_o)
        else $error("battery fields not restored");
    AST_TIMER_RR: assert property (register_reset_i |=>
        watchdog_limit_o == 2'h1 && termination_enable_o)
        else $error("timer fields not restored");
    AST_TIMER_WD_KEEP: assert property (wd_only |=>
        watchdog_limit_o == $past(watchdog_limit_o) && termination_enable_o)
        else $error("timer watchdog restore wrong");
    AST_WD_OFF: assert property (watchdog_limit_o == 2'h0 |->
        !watchdog_active_o) else $error("watchdog active at limit off");
    AST_WD_ON: assert property (
        watchdog_limit_o != 2'h0 && !discharge_mode_i |-> watchdog_active_o)
        else $error("watchdog inactive with limit set");
    AST_DOUBLE: assert property (safety_timer_doubled_o |->
        power_path_management_i) else $error("doubling outside power path");
    AST_MISC_RR: assert property (register_reset_i |=>
        temperature_monitor_enable_o && !battery_switch_off_o)
        else $error("misc fields not restored");
    AST_MISC_WD_KEEP: assert property (wd_only |=>
        battery_switch_off_o == $past(battery_switch_off_o))
        else $error("switch off bit changed by watchdog");
    cover property (register_reset_i);
    cover property (watchdog_expiry_reset_i);
    cover property (irq_o);
endmodule
bind charger_config_registers charger_cfg_monitor u_mon (.*);

// file: verification/charger_config_registers_tb_top.sv
`timescale 1ns/10ps
module charger_config_registers_tb_top;
    logic                             clk_sys_i, nrst_i, rr, wd, dis, power_path_management;
    logic                             irq, act, dbl, rec, ste, ptk;
    logic [1:0]                       fcl;
    logic [1:0]                       cs;
    logic [3:0]                       ev;
    logic [7:0]                       rdata, got;
    charger_cfg_pkg::reg_request_type req;
    int                               fail_count, total_checks, cycles;
    charger_host_model u_host (.clk_sys_i(clk_sys_i), .read_data_i(rdata),
        .req_o(req));
    charger_config_registers u_dut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
        .req_i(req), .register_reset_i(rr), .watchdog_expiry_reset_i(wd),
        .discharge_mode_i(dis), .power_path_management_i(power_path_management),
        .charge_state_i(cs), .events_i(ev), .read_data_o(rdata),
        .regulation_voltage_code_o(), .precharge_threshold_high_o(),
        .recharge_offset_large_o(rec), .watchdog_active_o(act),
        .watchdog_limit_o(), .termination_enable_o(),
        .safety_timer_enable_o(ste), .fast_charge_timer_length_o(fcl),
        .post_termination_charge_keep_o(ptk), .safety_timer_doubled_o(dbl),
        .temperature_monitor_enable_o(), .battery_switch_off_o(),
        .irq_o(irq));
    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            summarize();
        end
    end
    task automatic chk(input logic [7:0] g, e);
        total_checks++;
        if (g !== e) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, d);
        u_host.access(1'b1, a, d, got);
    endtask
    task automatic rd(input logic [7:0] a, e);
        u_host.access(1'b0, a, 8'h00, got);
        chk(got, e);
    endtask
    // Restore pulse: 1 host register reset, 0 watchdog expiry
    task automatic pulse(input logic r);
        @(posedge clk_sys_i);
        if (r) rr <= 1'b1;
        else wd <= 1'b1;
        @(posedge clk_sys_i);
        rr <= 1'b0;
        wd <= 1'b0;
    endtask
    task automatic step(input logic [3:0] e, input logic [1:0] s,
                        input logic x);
        @(posedge clk_sys_i);
        ev <= e;
        cs <= s;
        @(posedge clk_sys_i);
        ev <= 4'h0;
        #1 chk({7'h00, irq}, {7'h00, x});
    endtask
    task automatic t_defaults();
        rd(8'h04, charger_cfg_pkg::BATTERY_VOLTAGE_CONFIG_RESET);
        rd(8'h05, charger_cfg_pkg::TERMINATION_TIMER_CONFIG_RESET);
        rd(8'h06, charger_cfg_pkg::MISC_OPERATION_CONTROL_RESET);
        rd(8'h07, 8'h00);
        $display("test defaults done");
    endtask
    task automatic t_restore();
        for (int i = 4; i < 7; i++) wr(i[7:0], 8'hff);
        rd(8'h05, 8'hff);
        chk({4'h0, ste, fcl, ptk}, 8'h0f);
        chk({7'h00, ptk}, 8'h01);
        chk({7'h00, rec}, 8'h01);
        pulse(1'b0);
        rd(8'h04, 8'ha3);
        rd(8'h05, 8'hfa);
        rd(8'h06, 8'he0);
        pulse(1'b1);
        rd(8'h05, 8'h3a);
        rd(8'h06, 8'hc0);
        $display("test restore done");
    endtask
    task automatic t_watchdog();
        @(posedge clk_sys_i) dis <= 1'b1;
        wr(8'h05, 8'h20);
        chk({7'h00, act}, 8'h00);
        wr(8'h05, 8'ha0);
        chk({7'h00, act}, 8'h01);
        wr(8'h05, 8'h80);
        chk({7'h00, act}, 8'h00);
        @(posedge clk_sys_i) dis <= 1'b0;
        wr(8'h05, 8'h60);
        chk({7'h00, act}, 8'h01);
        @(posedge clk_sys_i) power_path_management <= 1'b1;
        wr(8'h06, 8'h40);
        chk({7'h00, dbl}, 8'h01);
        wr(8'h06, 8'h00);
        chk({7'h00, dbl}, 8'h00);
        $display("test watchdog done");
    endtask
    task automatic t_irq();
        for (int i = 0; i < 4; i++) step(4'h1 << i, 2'h0, 1'b1);
        step(4'h0, 2'h1, 1'b1);
        step(4'h0, 2'h2, 1'b1);
        step(4'h0, 2'h3, 1'b0);
        wr(8'h06, 8'h1f);
        step(4'hf, 2'h0, 1'b0);
        step(4'h0, 2'h1, 1'b0);
        $display("test irq done");
    endtask
    initial begin
        {nrst_i, rr, wd, dis, power_path_management, cs, ev} = '0;
        repeat (12) @(posedge clk_sys_i);
        nrst_i <= 1'b1;
        t_defaults();
        t_restore();
        t_watchdog();
        t_irq();
        summarize();
    end
endmodule

// file: verification/charger_host_model.sv
`timescale 1ns/10ps
module charger_host_model (
    input  wire logic                     clk_sys_i,
    input  wire logic [7:0]               read_data_i,
    output charger_cfg_pkg::reg_request_type req_o
);
    initial req_o = '0;
    // One access: strobe one cycle, take read data after its edge
    task automatic access(input logic w, input logic [7:0] a, d,
                          output logic [7:0] q);
        @(posedge clk_sys_i);
        req_o <= '{write: w, read: !w, address: a, data: d};
        @(posedge clk_sys_i);
        req_o <= '{write: 1'b0, read: 1'b0, address: ~a, data: ~d};
        #1 q = read_data_i;
    endtask
endmodule
